// ===== hdl/fre_pkg.sv
package fre_pkg;

    // ****************************************************************
    // event kinds on the source port
    // ****************************************************************
    typedef enum logic [3:0] {
        FRE_K_PROT,
        FRE_K_TCM,
        FRE_K_CACHE,
        FRE_K_PSRAM,
        FRE_K_MSIF,
        FRE_K_GROUP,
        FRE_K_FBUS,
        FRE_K_FMAIN,
        FRE_K_FWORK,
        FRE_K_FCACHE,
        FRE_K_SRAM
    } fre_kind_t;

    // ****************************************************************
    // fault indices
    // ****************************************************************
    localparam int          FRE_PROT_UNITS = 11;
    localparam logic [6:0]  FRE_PROT_IDX [FRE_PROT_UNITS] = '{
        7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
        7'h09, 7'h0A, 7'h0D, 7'h0E, 7'h0F};
    localparam logic [6:0]  FRE_IDX_TCM1    = 7'h10;
    localparam logic [6:0]  FRE_IDX_CACHE0  = 7'h12;
    localparam logic [6:0]  FRE_IDX_CACHE1  = 7'h14;
    localparam logic [6:0]  FRE_IDX_MSIF4   = 7'h19;
    localparam logic [6:0]  FRE_IDX_PSRAM   = 7'h1A;
    localparam logic [6:0]  FRE_IDX_MSIF0   = 7'h1C;
    localparam logic [6:0]  FRE_IDX_GROUP0  = 7'h20;
    localparam logic [6:0]  FRE_IDX_FBUSM   = 7'h30;
    localparam logic [6:0]  FRE_IDX_FMAIN   = 7'h31;
    localparam logic [6:0]  FRE_IDX_FBUSW   = 7'h33;
    localparam logic [6:0]  FRE_IDX_FWORK   = 7'h34;
    localparam logic [6:0]  FRE_IDX_FCACHE  = 7'h36;
    localparam logic [6:0]  FRE_IDX_TCM0    = 7'h38;
    localparam logic [6:0]  FRE_IDX_SRAM0   = 7'h3A;
    localparam logic [3:0]  FRE_MSIF_LAST   = 4'h4;
    localparam logic [3:0]  FRE_MSIF_ALT    = 4'h4;
    localparam logic [3:0]  FRE_GROUP_HOLE  = 4'h7;
    localparam logic [3:0]  FRE_GROUP_LAST  = 4'h9;
    localparam logic [3:0]  FRE_PAIR_LAST   = 4'h1;

    // ****************************************************************
    // payload field layout
    // ****************************************************************
    localparam int          FRE_P_ACC_LO    = 0;
    localparam int          FRE_P_NONSEC    = 6;
    localparam int          FRE_P_MID_LO    = 8;
    localparam int          FRE_P_CID_LO    = 12;
    localparam int          FRE_P_SHARED    = 31;
    localparam int          FRE_P_CAUSE_LO  = 28;
    localparam int          FRE_P_BANK_LO   = 30;
    localparam int          FRE_P_DCACHE    = 31;
    localparam logic [31:0] FRE_M_TCM_ADDR  = 32'h00FF_FFFC;
    localparam logic [31:0] FRE_M_CACHE_LOC = 32'h0001_FFFC;
    localparam logic [31:0] FRE_M_PSRAM     = 32'h0000_07FF;
    localparam logic [31:0] FRE_M_FLASH     = 32'h07FF_FFFF;
    localparam logic [31:0] FRE_M_SYN8      = 32'h0000_00FF;
    localparam logic [31:0] FRE_M_SYN7      = 32'h0000_007F;
    localparam logic [31:0] FRE_M_SYN7X4    = 32'h7F7F_7F7F;
    localparam logic [3:0]  FRE_CAUSE_GROUP = 4'h0;
    localparam logic [4:0]  FRE_FLASH_HI    = 5'h02;

    // ****************************************************************
    // register map, word index on the avalon bus
    // ****************************************************************
    localparam logic [3:0]  FRE_R_CTRL      = 4'h0;
    localparam logic [3:0]  FRE_R_STATUS    = 4'h1;
    localparam logic [3:0]  FRE_R_COUNT     = 4'h2;
    localparam logic [3:0]  FRE_R_REJECT    = 4'h3;
    localparam int          FRE_S_REJ       = 0;
    localparam int          FRE_S_DROP      = 1;
    localparam int          FRE_S_PEND      = 2;
    localparam int          FRE_S_IDX_LO    = 8;
    localparam logic        FRE_CTRL_RST    = 1'b1;

    // fault index for an event; bit 7 set when the index is assigned
    function automatic logic [7:0] fre_map(fre_kind_t k, logic [3:0] u,
                                           logic nc);
        logic [6:0] b;
        logic       ok;
        b  = 7'h00;
        ok = 1'b1;
        case (k)
            FRE_K_PROT: begin
                ok = (u < 4'(FRE_PROT_UNITS));
                b  = ok ? FRE_PROT_IDX[u] : 7'h00;
            end
            FRE_K_TCM:    b = (u[0] ? FRE_IDX_TCM1 : FRE_IDX_TCM0)
                              + {6'h00, nc};
            FRE_K_CACHE:  b = (u[0] ? FRE_IDX_CACHE1 : FRE_IDX_CACHE0)
                              + {6'h00, nc};
            FRE_K_PSRAM:  b = FRE_IDX_PSRAM + {6'h00, nc};
            FRE_K_MSIF: begin
                ok = (u <= FRE_MSIF_LAST);
                b  = (u == FRE_MSIF_ALT) ? FRE_IDX_MSIF4
                                         : FRE_IDX_MSIF0 + {3'h0, u};
            end
            FRE_K_GROUP: begin
                ok = (u <= FRE_GROUP_LAST) && (u != FRE_GROUP_HOLE);
                b  = FRE_IDX_GROUP0 + {3'h0, u};
            end
            FRE_K_FBUS:   b = u[0] ? FRE_IDX_FBUSW : FRE_IDX_FBUSM;
            FRE_K_FMAIN:  b = FRE_IDX_FMAIN + {6'h00, nc};
            FRE_K_FWORK:  b = FRE_IDX_FWORK + {6'h00, nc};
            FRE_K_FCACHE: b = FRE_IDX_FCACHE + {6'h00, nc};
            FRE_K_SRAM: begin
                ok = (u <= FRE_PAIR_LAST);
                b  = FRE_IDX_SRAM0 + {5'h00, u[0], nc};
            end
            default:      ok = 1'b0;
        endcase
        return {ok, b};
    endfunction

endpackage

// ===== hdl/fre_encoder.sv
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module fre_encoder
    import fre_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset,
    // fault event from protection logic
    input  wire logic                ev_valid,
    input  wire fre_pkg::fre_kind_t  ev_kind,
    input  wire logic [3:0]          ev_unit,
    input  wire logic                ev_uncorr,
    input  wire logic [31:0]         ev_addr,
    input  wire logic [5:0]          ev_access,
    input  wire logic                ev_nonsec,
    input  wire logic [3:0]          ev_master_id,
    input  wire logic [3:0]          ev_context_id,
    input  wire logic                ev_shared,
    input  wire logic [3:0]          ev_cause,
    input  wire logic [1:0]          ev_bank,
    input  wire logic [31:0]         ev_syndrome,
    output logic                     ev_ready_q,
    // fault report to the collection structures
    output logic                     fault_valid_q,
    output logic [6:0]               fault_index_q,
    output logic [31:0]              fault_payload_first_q,
    output logic [31:0]              fault_payload_second_q,
    input  wire logic                fault_ready,
    // avalon-mm slave
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata_q,
    output logic                     avs_waitrequest_q
);
    import fre_pkg::*;

    // ****************************************************************
    // payload packing
    // ****************************************************************
    // protection-style payload shared by bus master, master interface
    // and group violations; cause field only used by the latter two
    function automatic logic [31:0] prot_second(logic [5:0] acc,
        logic ns, logic [3:0] mid, logic [3:0] cid);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[FRE_P_ACC_LO +: 6] = acc;
        w[FRE_P_NONSEC]      = ns;
        w[FRE_P_MID_LO +: 4] = mid;
        w[FRE_P_CID_LO +: 4] = cid;
        return w;
    endfunction

    logic [7:0]  map_w;
    logic [31:0] first_w;
    logic [31:0] second_w;

    always_comb begin
        map_w    = fre_map(ev_kind, ev_unit, ev_uncorr);
        first_w  = 32'h0000_0000;
        second_w = 32'h0000_0000;
        case (ev_kind)
            FRE_K_PROT: begin
                first_w  = ev_addr;
                second_w = prot_second(ev_access, ev_nonsec,
                                       ev_master_id, ev_context_id);
                second_w[FRE_P_SHARED] = ev_shared;
            end
            FRE_K_TCM: begin
                first_w  = ev_addr & FRE_M_TCM_ADDR;
                second_w = ev_syndrome & FRE_M_SYN8;
                second_w[FRE_P_BANK_LO +: 2] = ev_bank;
            end
            FRE_K_CACHE: begin
                first_w  = ev_addr & FRE_M_CACHE_LOC;
                first_w[FRE_P_DCACHE] = ev_bank[0];
            end
            FRE_K_PSRAM: begin
                first_w  = ev_addr & FRE_M_PSRAM;
                second_w = ev_syndrome & FRE_M_SYN8;
            end
            FRE_K_MSIF: begin
                first_w  = ev_addr;
                second_w = prot_second(ev_access, ev_nonsec,
                                       ev_master_id, ev_context_id);
                second_w[FRE_P_CAUSE_LO +: 4] = ev_cause;
            end
            FRE_K_GROUP: begin
                first_w  = ev_addr;
                second_w = prot_second(ev_access, ev_nonsec,
                                       ev_master_id, ev_context_id);
                second_w[FRE_P_CAUSE_LO +: 4] = FRE_CAUSE_GROUP;
            end
            FRE_K_FBUS: begin
                // consumer prefixes the fixed flash pattern itself
                first_w  = ev_addr & FRE_M_FLASH;
                second_w[FRE_P_MID_LO +: 4] = ev_master_id;
            end
            FRE_K_FMAIN: begin
                first_w  = ev_addr & FRE_M_FLASH;
                second_w = ev_syndrome;
            end
            FRE_K_FWORK: begin
                first_w  = ev_addr & FRE_M_FLASH;
                second_w = ev_syndrome & FRE_M_SYN7;
            end
            FRE_K_FCACHE: begin
                first_w  = ev_addr & FRE_M_FLASH;
                second_w = ev_syndrome & FRE_M_SYN7X4;
            end
            FRE_K_SRAM: begin
                first_w  = ev_addr;
                second_w = ev_syndrome & FRE_M_SYN7;
            end
            default: begin
                first_w  = 32'h0000_0000;
                second_w = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // report slot
    // ****************************************************************
    // a single slot: the source stalls while a report is unclaimed,
    // so nothing is lost but throughput is one fault per handshake
    logic        enable_q;
    logic        take_w;
    logic        legal_w;
    logic        valid_d;
    logic        ready_d;
    logic [6:0]  index_d;
    logic [31:0] first_d;
    logic [31:0] second_d;

    always_comb begin
        take_w   = ev_valid && ev_ready_q;
        legal_w  = map_w[7];
        valid_d  = fault_valid_q && !fault_ready;
        index_d  = fault_index_q;
        first_d  = fault_payload_first_q;
        second_d = fault_payload_second_q;
        if (take_w && legal_w && enable_q) begin
            valid_d  = 1'b1;
            index_d  = map_w[6:0];
            first_d  = first_w;
            second_d = second_w;
        end
        ready_d = !valid_d;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_valid_q          <= 1'b0;
            ev_ready_q             <= 1'b0;
            fault_index_q          <= 7'h00;
            fault_payload_first_q  <= 32'h0000_0000;
            fault_payload_second_q <= 32'h0000_0000;
        end else begin
            fault_valid_q          <= valid_d;
            ev_ready_q             <= ready_d;
            fault_index_q          <= index_d;
            fault_payload_first_q  <= first_d;
            fault_payload_second_q <= second_d;
        end
    end

    // ****************************************************************
    // avalon register slave
    // ****************************************************************
    typedef enum logic {FRE_BUS_IDLE, FRE_BUS_DONE} fre_bus_t;

    fre_bus_t    bus_q, bus_d;
    logic        enable_d;
    logic        rej_q, rej_d;
    logic        drop_q, drop_d;
    logic [15:0] count_q, count_d;
    logic [15:0] rcount_q, rcount_d;
    logic [31:0] rdata_d;
    logic        wait_d;
    logic        wr_w;
    logic        rej_ev_w;
    logic        drop_ev_w;

    always_comb begin
        bus_d     = bus_q;
        wait_d    = 1'b1;
        rdata_d   = avs_readdata_q;
        enable_d  = enable_q;
        rej_ev_w  = take_w && !legal_w;
        drop_ev_w = take_w && legal_w && !enable_q;
        wr_w      = 1'b0;
        case (bus_q)
            FRE_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d  = FRE_BUS_DONE;
                    wait_d = 1'b0;
                    if (avs_address == FRE_R_CTRL) begin
                        rdata_d = {31'h0000_0000, enable_q};
                    end else if (avs_address == FRE_R_STATUS) begin
                        rdata_d = 32'h0000_0000;
                        rdata_d[FRE_S_REJ]  = rej_q;
                        rdata_d[FRE_S_DROP] = drop_q;
                        rdata_d[FRE_S_PEND] = fault_valid_q;
                        rdata_d[FRE_S_IDX_LO +: 7] = fault_index_q;
                    end else if (avs_address == FRE_R_COUNT) begin
                        rdata_d = {16'h0000, count_q};
                    end else if (avs_address == FRE_R_REJECT) begin
                        rdata_d = {16'h0000, rcount_q};
                    end else begin
                        rdata_d = 32'h0000_0000;
                    end
                end
            end
            FRE_BUS_DONE: begin
                bus_d  = FRE_BUS_IDLE;
                // writes land at the edge that completes the transfer
                wr_w   = avs_write;
            end
            default: bus_d = FRE_BUS_IDLE;
        endcase
        if (wr_w && avs_address == FRE_R_CTRL && avs_byteenable[0]) begin
            enable_d = avs_writedata[0];
        end
        // write-one-to-clear; a same-cycle event keeps the flag set
        rej_d  = rej_q;
        drop_d = drop_q;
        if (wr_w && avs_address == FRE_R_STATUS && avs_byteenable[0]) begin
            rej_d  = rej_q  && !avs_writedata[FRE_S_REJ];
            drop_d = drop_q && !avs_writedata[FRE_S_DROP];
        end
        if (rej_ev_w) begin
            rej_d = 1'b1;
        end
        if (drop_ev_w) begin
            drop_d = 1'b1;
        end
        count_d  = count_q + 16'((take_w && legal_w && enable_q) ? 1 : 0);
        rcount_d = rcount_q + 16'(rej_ev_w ? 1 : 0);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_q             <= FRE_BUS_IDLE;
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q    <= 32'h0000_0000;
            enable_q          <= FRE_CTRL_RST;
            rej_q             <= 1'b0;
            drop_q            <= 1'b0;
            count_q           <= 16'h0000;
            rcount_q          <= 16'h0000;
        end else begin
            bus_q             <= bus_d;
            avs_waitrequest_q <= wait_d;
            avs_readdata_q    <= rdata_d;
            enable_q          <= enable_d;
            rej_q             <= rej_d;
            drop_q            <= drop_d;
            count_q           <= count_d;
            rcount_q          <= rcount_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence acc_s(fre_kind_t k);
        take_w && legal_w && enable_q && ev_kind == k;
    endsequence

    sequence rep_s;
        fault_valid_q ##0 !$stable(fault_index_q) || fault_valid_q;
    endsequence

    prot_addr_a: assert property (acc_s(FRE_K_PROT) |=> rep_s and
        (fault_payload_first_q == $past(ev_addr)))
        else $error("protection address not reported");
    prot_ids_a: assert property (acc_s(FRE_K_PROT) |=>
        fault_payload_second_q[15:0] == {$past(ev_context_id),
        $past(ev_master_id), 1'b0, $past(ev_nonsec), $past(ev_access)})
        else $error("protection ids wrong");
    shared_bit_a: assert property (acc_s(FRE_K_PROT) |=>
        fault_payload_second_q[31] == $past(ev_shared))
        else $error("shared unit flag wrong");
    prot_index_a: assert property (acc_s(FRE_K_PROT) |=>
        fault_index_q inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
        7'h09, 7'h0A, 7'h0D, 7'h0E, 7'h0F})
        else $error("protection index out of set");
    tcm_fields_a: assert property (acc_s(FRE_K_TCM) |=>
        fault_payload_second_q[31:30] == $past(ev_bank) &&
        fault_payload_first_q[1:0] == 2'h0 &&
        fault_payload_first_q[31:24] == 8'h00)
        else $error("coupled ram payload wrong");
    tcm_index_a: assert property (acc_s(FRE_K_TCM) |=>
        fault_index_q == ($past(ev_unit[0]) ? 7'h10 : 7'h38)
        + {6'h00, $past(ev_uncorr)})
        else $error("coupled ram index wrong");
    cache_a: assert property (acc_s(FRE_K_CACHE) |=>
        fault_payload_first_q[31] == $past(ev_bank[0]) &&
        fault_index_q[6:2] == 5'h04 + {4'h0, $past(ev_unit[0])})
        else $error("cache report wrong");
    cache_odd_a: assert property (acc_s(FRE_K_CACHE) |=>
        fault_index_q[0] == $past(ev_uncorr))
        else $error("cache parity of index wrong");
    psram_a: assert property (acc_s(FRE_K_PSRAM) |=>
        fault_index_q[6:1] == 6'h0D && fault_payload_first_q[31:11] == 0)
        else $error("protection sram report wrong");
    msif_a: assert property (acc_s(FRE_K_MSIF) |=>
        fault_payload_second_q[31:28] == $past(ev_cause))
        else $error("master interface cause wrong");
    msif_idx_a: assert property (acc_s(FRE_K_MSIF) |=>
        fault_index_q inside {7'h19, 7'h1C, 7'h1D, 7'h1E, 7'h1F})
        else $error("master interface index wrong");
    group_a: assert property (acc_s(FRE_K_GROUP) |=>
        fault_payload_second_q[31:28] == 4'h0 &&
        fault_payload_first_q == $past(ev_addr))
        else $error("group payload wrong");
    group_idx_a: assert property (acc_s(FRE_K_GROUP) |=>
        fault_index_q inside {[7'h20:7'h26], 7'h28, 7'h29})
        else $error("group index wrong");
    flash_bus_a: assert property (acc_s(FRE_K_FBUS) |=>
        fault_payload_first_q[31:27] == 5'h00 &&
        fault_index_q == ($past(ev_unit[0]) ? 7'h33 : 7'h30))
        else $error("flash bus error wrong");
    fmain_a: assert property (acc_s(FRE_K_FMAIN) |=>
        fault_payload_second_q == $past(ev_syndrome))
        else $error("main flash syndromes wrong");
    fwork_a: assert property (acc_s(FRE_K_FWORK) |=>
        fault_payload_second_q[31:7] == 0 && fault_index_q[6:1] == 6'h1A)
        else $error("work flash report wrong");
    fcache_a: assert property (acc_s(FRE_K_FCACHE) |=>
        (fault_payload_second_q & 32'h8080_8080) == 0)
        else $error("flash cache syndromes wrong");
    sram_a: assert property (acc_s(FRE_K_SRAM) |=>
        fault_index_q inside {[7'h3A:7'h3D]} &&
        fault_payload_first_q == $past(ev_addr))
        else $error("system ram report wrong");
    pair_a: assert property (take_w && legal_w && enable_q &&
        ev_uncorr && ev_kind inside {FRE_K_TCM, FRE_K_CACHE, FRE_K_PSRAM,
        FRE_K_FMAIN} |=> fault_index_q == $past(map_w[6:0]) &&
        $past(fre_map(ev_kind, ev_unit, 1'b0)) + 8'h01 ==
        {1'b1, fault_index_q})
        else $error("uncorrectable index not adjacent");
    no_hole_a: assert property (fault_valid_q |->
        !(fault_index_q inside {[7'h06:7'h08], 7'h0B, 7'h0C,
        [7'h16:7'h18], 7'h27, [7'h2A:7'h2F]}))
        else $error("unassigned index raised");

endmodule // fre_encoder

// ===== dv/fre_sink.sv
`timescale 1ns/100ps
module fre_sink (
    // report handshake
    input  wire logic clk_sys,
    output logic      fault_ready = 1'b0
);
    // random stalls keep a report standing for several cycles
    always @(posedge clk_sys) begin
        fault_ready <= ($urandom % 3) == 0;
    end
endmodule // fre_sink

// ===== dv/fre_encoder_tb_top.sv
`timescale 1ns/100ps
module fre_encoder_tb_top;
    import fre_pkg::*;
    localparam logic [31:0] ONES = 32'hFFFFFFFF;
    localparam logic [6:0] PT [11] = '{7'h00, 7'h01, 7'h02, 7'h03,
        7'h04, 7'h05, 7'h09, 7'h0A, 7'h0D, 7'h0E, 7'h0F};
    logic clk_sys = 1'b0, reset = 1'b1, ev_valid = 1'b0, e_ok;
    logic ev_uncorr = 1'b0, ev_nonsec = 1'b0, ev_shared = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, fault_ready;
    logic ev_ready_q, fault_valid_q, avs_waitrequest_q;
    fre_kind_t ev_kind = FRE_K_PROT;
    logic [3:0] ev_unit = 4'h0, ev_master_id = 4'h0, ev_context_id = 4'h0;
    logic [3:0] ev_cause = 4'h0, avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [5:0] ev_access = 6'h00;
    logic [1:0] ev_bank = 2'h0;
    logic [6:0] fault_index_q, e_n;
    logic [31:0] ev_addr = 32'h0, ev_syndrome = 32'h0, avs_writedata = 32'h0;
    logic [31:0] fault_payload_first_q, fault_payload_second_q;
    logic [31:0] avs_readdata_q, rd, fm, sm, ef, es;
    int num_errors = 0, n_tests = 0, n_rep = 0, n_rej = 0;
    fre_encoder u_dut (
        .clk_sys(clk_sys), .reset(reset), .ev_valid(ev_valid),
        .ev_kind(ev_kind), .ev_unit(ev_unit), .ev_uncorr(ev_uncorr),
        .ev_addr(ev_addr), .ev_access(ev_access), .ev_nonsec(ev_nonsec),
        .ev_master_id(ev_master_id), .ev_context_id(ev_context_id),
        .ev_shared(ev_shared), .ev_cause(ev_cause), .ev_bank(ev_bank),
        .ev_syndrome(ev_syndrome), .ev_ready_q(ev_ready_q),
        .fault_valid_q(fault_valid_q), .fault_index_q(fault_index_q),
        .fault_payload_first_q(fault_payload_first_q),
        .fault_payload_second_q(fault_payload_second_q),
        .fault_ready(fault_ready), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata_q(avs_readdata_q),
        .avs_waitrequest_q(avs_waitrequest_q));
    fre_sink u_sink (.clk_sys(clk_sys), .fault_ready(fault_ready));
    always #20 clk_sys = ~clk_sys;
    task summarize();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // bounded wait, sampled mid-cycle where outputs are settled
    task automatic wt(ref logic s, input logic v);
        int i;
        for (i = 0; i < 50 && s !== v; i++) @(negedge clk_sys);
        if (s !== v) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask
    // request held until the rising edge that sees waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest_q === 1'b0) break;
        end
        rd = avs_readdata_q;
        {avs_read, avs_write} <= 2'b00;
        if (i == 50) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask
    function automatic void calc();
        logic [31:0] pr;
        logic [3:0] u;
        logic [6:0] c;
        u = ev_unit;
        c = 7'(ev_uncorr);
        pr = {16'h0, ev_context_id, ev_master_id, 1'b0, ev_nonsec, ev_access};
        {e_ok, fm, sm, es} = {1'b1, 32'h07FFFFFF, 32'h7F, ev_syndrome & 32'h7F};
        case (ev_kind)
        FRE_K_PROT: {e_ok, e_n, fm, sm, es} = {u < 4'hB, PT[u % 11], ONES,
            32'h8000FF7F, pr | {ev_shared, 31'h0}};
        FRE_K_TCM: {e_n, fm, sm, es} = {(u[0] ? 7'h10 : 7'h38) + c, 32'hFFFFFC,
            32'hC00000FF, ev_bank, 22'h0, ev_syndrome[7:0]};
        FRE_K_CACHE: {e_n, fm, sm, es} = {(u[0] ? 7'h14 : 7'h12) + c,
            32'h8001FFFC, ONES, 32'h0};
        FRE_K_PSRAM: {e_n, fm, sm, es} = {7'h1A + c, 32'h7FF, 32'hFF,
            24'h0, ev_syndrome[7:0]};
        FRE_K_MSIF: {e_ok, e_n, fm, sm, es} = {u < 4'h5, u == 4'h4 ? 7'h19 :
            7'h1C + 7'(u), ONES, 32'hF000FF7F, pr | {ev_cause, 28'h0}};
        FRE_K_GROUP: {e_ok, e_n, fm, sm, es} = {u < 4'hA && u != 4'h7,
            7'h20 + 7'(u), ONES, 32'hF000FF7F, pr};
        FRE_K_FBUS: {e_n, sm, es} = {u[0] ? 7'h33 : 7'h30, 32'hF00, 20'h0,
            ev_master_id, 8'h0};
        FRE_K_FMAIN: {e_n, sm, es} = {7'h31 + c, ONES, ev_syndrome};
        FRE_K_FWORK: e_n = 7'h34 + c;
        FRE_K_FCACHE: {e_n, sm, es} = {7'h36 + c, 32'h7F7F7F7F,
            ev_syndrome & 32'h7F7F7F7F};
        FRE_K_SRAM: {e_ok, e_n, fm} = {u < 4'h2, 7'h3A + {u[0], c[0]}, ONES};
        default: e_ok = 1'b0;
        endcase
        ef = ev_addr & fm;
        if (ev_kind == FRE_K_CACHE) ef[31] = ev_bank[0];
    endfunction
    // event held until the rising edge that sees the slot free
    task send(input logic en);
        int i;
        ev_valid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (ev_ready_q === 1'b1) break;
        end
        calc();
        ev_valid <= 1'b0;
        if (i == 50) begin
            chk(32'h0, 32'h1);
            summarize();
        end
        if (en && e_ok) begin
            @(negedge clk_sys);
            wt(fault_valid_q, 1'b1);
            n_rep++;
            chk(32'(fault_index_q), 32'(e_n));
            chk(fault_payload_first_q & fm, ef);
            chk(fault_payload_second_q & sm, es);
        end else begin
            n_rej += 32'(!e_ok);
            repeat (3) @(negedge clk_sys) chk(32'(fault_valid_q), 0);
        end
    endtask
    initial begin
        int i, w, b;
        w = $urandom(32'h7B548140);
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, 4'hF, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            w = $urandom_range(0, 11);
            b = $urandom_range(1, 3);
            ev_kind <= fre_kind_t'(i % 11);
            ev_unit <= 4'((i % 11) inside {0, 4, 5, 10} ? w : w % 2);
            ev_bank <= 2'(b == 1 ? 0 : b);
            ev_cause <= (i % 11 == 4) ? 4'($urandom_range(0, 2)) : 4'h0;
            {ev_addr, ev_syndrome} <= {$urandom, $urandom};
            {ev_uncorr, ev_nonsec, ev_shared, ev_access, ev_master_id,
                ev_context_id} <= 17'($urandom);
            send(1'b1);
        end
        bus(1'b0, 4'h2, 32'h0);
        chk(rd & 32'hFFFF, n_rep);
        bus(1'b0, 4'h3, 32'h0);
        chk(rd & 32'hFFFF, n_rej);
        bus(1'b1, 4'h1, 32'h3);
        bus(1'b1, 4'h0, 32'h0);
        @(posedge clk_sys);
        ev_kind <= FRE_K_PROT;
        ev_unit <= 4'h0;
        send(1'b0);
        bus(1'b0, 4'h1, 32'h0);
        chk(rd & 32'h7, 32'h2);
        summarize();
    end
endmodule // fre_encoder_tb_top
